//--- rtl/fmt_dec_pkg.sv
// Constants for the instruction format decoder
package fmt_dec_pkg;
  localparam logic [7:0] ESC_CB    = 8'hCB;
  localparam logic [7:0] ESC_ED    = 8'hED;
  localparam logic [7:0] ESC_DD    = 8'hDD;
  localparam logic [7:0] ESC_FD    = 8'hFD;
  // Directive prefix is escape DD or FD followed by one of eight codes
  localparam logic [7:0] DIR_BASE  = 8'hC0;
  localparam logic [7:0] DIR_MASK  = 8'hF8;
  // Codes of the directive group that extend displacements (C1..C3)
  localparam logic [1:0] DIR_IM_LO = 2'h1;
  localparam logic [1:0] DIR_IM_HI = 2'h3;
  localparam logic [1:0] MAX_DISP  = 2'h3;
  localparam int         IMM_BYTES = 2;
  localparam logic [1:0] FMT_1     = 2'h0;
  localparam logic [1:0] FMT_2     = 2'h1;
  localparam logic [1:0] FMT_3     = 2'h2;
  localparam logic [1:0] FMT_4     = 2'h3;
  localparam logic [1:0] AM_NONE   = 2'h0;
  localparam logic [1:0] AM_FIRST  = 2'h1;
  localparam logic [1:0] AM_SECOND = 2'h2;
  // Immediate-word opcodes after ED CB: low three bits all ones, top set
  localparam logic [7:0] IMW_MASK  = 8'h87;
  localparam logic [7:0] IMW_VAL   = 8'h87;
endpackage : fmt_dec_pkg

//--- rtl/fmt_dec.sv
// Instruction format decoder: byte stream in, classified instruction out
`timescale 1ns/1ns
// How it works
// - Exactly one operation byte per instruction
// - Extract addressing and register fields from opcode
// - Separate addressing escapes from operation escapes
// - No escape is format one, single ED, DD or FD is two
// - Escape CB gives format three
// - ED then CB gives format four
// - DD and FD also act as operation escapes
// - Formats two and four: opcode follows escape directly
// - Indexed format three captures one displacement byte
// - After immediate directive, one to three displacement
// - Format four may take trailing immediate word
// - Addressing escape only as first byte
// - Addressing escape changes addressing field meaning
// - Same opcode decodes by its escape
// - Recognise eight decoder directive prefixes
// - Immediate directive extends following displacement
module fmt_dec
  import fmt_dec_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK_SYS_IN,
  input  wire logic        RST_N_IN,
  // Fetch side
  input  wire logic        BYTE_VALID_IN,
  input  wire logic [7:0]  BYTE_IN,
  output logic             BYTE_READY_OUT,
  // Decoded instruction
  output logic             DONE_OUT,
  output logic [1:0]       FORMAT_OUT,
  output logic [1:0]       ADDR_ESC_OUT,
  output logic [7:0]       OPCODE_OUT,
  output logic [1:0]       OP_MODE_OUT,
  output logic [2:0]       OP_DST_OUT,
  output logic [2:0]       OP_SRC_OUT,
  output logic [23:0]      DISP_OUT,
  output logic [1:0]       DISP_LEN_OUT,
  output logic [15:0]      IMM_OUT,
  output logic             IMM_VALID_OUT,
  output logic             DIRECTIVE_OUT,
  output logic [2:0]       DIRECTIVE_CODE_OUT
);

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  typedef enum {ST_FIRST, ST_AFTER_AM, ST_AFTER_ED, ST_DISP,
                ST_OPC_CB, ST_IMM} state_e;

  state_e      state_r;
  state_e      state_nxt;
  logic        take;
  logic [1:0]  am_r;
  logic [1:0]  fmt_r;
  logic [1:0]  disp_need_r;
  logic [1:0]  disp_cnt_r;
  logic [23:0] disp_r;
  logic        imm_cnt_r;
  logic [7:0]  imm_lo_r;
  logic [7:0]  opc_r;
  logic        ext_pend_r;
  logic [1:0]  ext_len_r;
  logic        is_dir;
  logic        fin_op;
  logic        fin_imm;
  logic        fin_dir;
  logic        need_imm;

  assign take = BYTE_VALID_IN & BYTE_READY_OUT;
  assign is_dir = ((BYTE_IN & DIR_MASK) == DIR_BASE);
  // Immediate word for selected format four opcodes
  assign need_imm = ((BYTE_IN & IMW_MASK) == IMW_VAL);

  always_comb begin
    state_nxt = state_r;
    fin_op    = 1'b0;
    fin_imm   = 1'b0;
    fin_dir   = 1'b0;
    if (take) begin
      case (state_r)
        ST_FIRST: begin
          if (BYTE_IN == ESC_DD || BYTE_IN == ESC_FD) begin
            state_nxt = ST_AFTER_AM;
          end else if (BYTE_IN == ESC_CB) begin
            state_nxt = ST_OPC_CB;
          end else if (BYTE_IN == ESC_ED) begin
            state_nxt = ST_AFTER_ED;
          end else begin
            fin_op = 1'b1;
          end
        end
        ST_AFTER_AM: begin
          if (is_dir) begin
            fin_dir   = 1'b1;
            state_nxt = ST_FIRST;
          end else if (BYTE_IN == ESC_CB) begin
            state_nxt = ST_DISP;
          end else if (BYTE_IN == ESC_ED) begin
            state_nxt = ST_AFTER_ED;
          end else begin
            fin_op = 1'b1;
          end
        end
        ST_AFTER_ED: begin
          if (BYTE_IN == ESC_CB) begin
            state_nxt = ST_OPC_CB;
          end else begin
            fin_op = 1'b1;
          end
        end
        ST_DISP: begin
          if (disp_cnt_r + 2'h1 >= disp_need_r) begin
            state_nxt = ST_OPC_CB;
          end
        end
        ST_OPC_CB: begin
          if (fmt_r == FMT_4 && need_imm) begin
            state_nxt = ST_IMM;
          end else begin
            fin_op = 1'b1;
          end
        end
        ST_IMM: fin_imm = imm_cnt_r;
        default: state_nxt = ST_FIRST;
      endcase
      if (fin_op || fin_imm) begin
        state_nxt = ST_FIRST;
      end
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_r <= ST_FIRST;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************************************
  // Escape and format tracking
  // ****************************************************************
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      am_r  <= AM_NONE;
      fmt_r <= FMT_1;
    end else if (take) begin
      case (state_r)
        ST_FIRST: begin
          am_r <= (BYTE_IN == ESC_DD) ? AM_FIRST :
                  (BYTE_IN == ESC_FD) ? AM_SECOND : AM_NONE;
          fmt_r <= (BYTE_IN == ESC_CB) ? FMT_3 :
                   (BYTE_IN == ESC_ED) ? FMT_2 : FMT_1;
        end
        ST_AFTER_AM: begin
          fmt_r <= (BYTE_IN == ESC_CB) ? FMT_3 : FMT_2;
        end
        ST_AFTER_ED: begin
          if (BYTE_IN == ESC_CB) begin
            fmt_r <= FMT_4;
          end
        end
        default: fmt_r <= fmt_r;
      endcase
    end
  end

  // ****************************************************************
  // Displacement and directive extension
  // ****************************************************************
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ext_pend_r <= 1'b0;
      ext_len_r  <= 2'h1;
    end else if (fin_dir) begin
      ext_pend_r <= (BYTE_IN[1:0] >= DIR_IM_LO) && !BYTE_IN[2];
      ext_len_r  <= BYTE_IN[1:0];
    end else if (fin_op || fin_imm) begin
      ext_pend_r <= 1'b0;
      ext_len_r  <= 2'h1;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      disp_need_r <= 2'h1;
      disp_cnt_r  <= 2'h0;
      disp_r      <= 24'h000000;
    end else if (take && state_r == ST_AFTER_AM &&
                 BYTE_IN == ESC_CB) begin
      // One to three bytes after directive
      disp_need_r <= ext_pend_r ? ext_len_r : 2'h1;
      disp_cnt_r  <= 2'h0;
      disp_r      <= 24'h000000;
    end else if (take && state_r == ST_DISP) begin
      disp_r[disp_cnt_r*8 +: 8] <= BYTE_IN;
      disp_cnt_r                <= disp_cnt_r + 2'h1;
    end else if (take && state_r == ST_FIRST) begin
      disp_cnt_r <= 2'h0;
      disp_r     <= 24'h000000;
    end
  end

  // ****************************************************************
  // Immediate word
  // ****************************************************************
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      imm_cnt_r <= 1'b0;
      imm_lo_r  <= 8'h00;
      opc_r     <= 8'h00;
    end else if (take && state_r == ST_IMM) begin
      imm_cnt_r <= ~imm_cnt_r;
      imm_lo_r  <= BYTE_IN;
    end else if (take && state_r == ST_OPC_CB) begin
      opc_r     <= BYTE_IN;
    end else if (take && state_r == ST_FIRST) begin
      imm_cnt_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Output registers
  // ****************************************************************
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      BYTE_READY_OUT     <= 1'b0;
      DONE_OUT           <= 1'b0;
      FORMAT_OUT         <= FMT_1;
      ADDR_ESC_OUT       <= AM_NONE;
      OPCODE_OUT         <= 8'h00;
      OP_MODE_OUT        <= 2'h0;
      OP_DST_OUT         <= 3'h0;
      OP_SRC_OUT         <= 3'h0;
      DISP_OUT           <= 24'h000000;
      DISP_LEN_OUT       <= 2'h0;
      IMM_OUT            <= 16'h0000;
      IMM_VALID_OUT      <= 1'b0;
      DIRECTIVE_OUT      <= 1'b0;
      DIRECTIVE_CODE_OUT <= 3'h0;
    end else begin
      BYTE_READY_OUT <= 1'b1;
      DONE_OUT       <= fin_op | fin_imm;
      DIRECTIVE_OUT  <= fin_dir;
      DIRECTIVE_CODE_OUT <= fin_dir ? BYTE_IN[2:0] : DIRECTIVE_CODE_OUT;
      if (fin_op) begin
        OPCODE_OUT    <= BYTE_IN;
        // Mode and register fields of opcode
        OP_MODE_OUT   <= BYTE_IN[7:6];
        OP_DST_OUT    <= BYTE_IN[5:3];
        OP_SRC_OUT    <= BYTE_IN[2:0];
        FORMAT_OUT    <= (state_r == ST_AFTER_AM) ? FMT_2 :
                         (state_r == ST_FIRST) ? FMT_1 : fmt_r;
        ADDR_ESC_OUT  <= (state_r == ST_FIRST) ? AM_NONE : am_r;
        DISP_OUT      <= (state_r == ST_OPC_CB) ? disp_r : 24'h000000;
        DISP_LEN_OUT  <= (state_r == ST_OPC_CB) ? disp_cnt_r : 2'h0;
        IMM_OUT       <= 16'h0000;
        IMM_VALID_OUT <= 1'b0;
      end else if (fin_imm) begin
        OPCODE_OUT    <= opc_r;
        OP_MODE_OUT   <= opc_r[7:6];
        OP_DST_OUT    <= opc_r[5:3];
        OP_SRC_OUT    <= opc_r[2:0];
        FORMAT_OUT    <= FMT_4;
        ADDR_ESC_OUT  <= am_r;
        DISP_OUT      <= 24'h000000;
        DISP_LEN_OUT  <= 2'h0;
        IMM_OUT       <= {BYTE_IN, imm_lo_r};
        IMM_VALID_OUT <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_N_IN);

  a_plain_format_one: assert property (
    (take && state_r == ST_FIRST && BYTE_IN != ESC_CB &&
     BYTE_IN != ESC_ED && BYTE_IN != ESC_DD && BYTE_IN != ESC_FD)
    |=> DONE_OUT && FORMAT_OUT == FMT_1 && OPCODE_OUT == $past(BYTE_IN))
    else $error("plain opcode not format one");
  a_cb_format_three: assert property (
    (take && state_r == ST_FIRST && BYTE_IN == ESC_CB)
    ##1 (take && state_r == ST_OPC_CB) |=> DONE_OUT && FORMAT_OUT == FMT_3)
    else $error("CB opcode not format three");
  a_edcb_format_four: assert property (
    (take && state_r == ST_AFTER_ED && BYTE_IN == ESC_CB)
    |=> state_r == ST_OPC_CB && fmt_r == FMT_4)
    else $error("ED CB not format four");
  a_ed_direct_opcode: assert property (
    (take && state_r == ST_AFTER_ED && BYTE_IN != ESC_CB)
    |=> DONE_OUT && FORMAT_OUT == FMT_2)
    else $error("opcode after ED not taken");
  a_indexed_one_disp: assert property (
    (take && state_r == ST_DISP && disp_cnt_r == 2'h0 && !ext_pend_r)
    |=> state_r == ST_OPC_CB)
    else $error("indexed CB displacement length wrong");
  a_disp_len_nonzero: assert property (
    (DONE_OUT && FORMAT_OUT == FMT_3 && ADDR_ESC_OUT != AM_NONE)
    |-> DISP_LEN_OUT != 2'h0)
    else $error("indexed displacement missing");
  a_dd_escape_fmt: assert property (
    (take && state_r == ST_AFTER_AM && !is_dir && BYTE_IN != ESC_CB &&
     BYTE_IN != ESC_ED) |=> DONE_OUT && FORMAT_OUT == FMT_2 &&
     ADDR_ESC_OUT != AM_NONE)
    else $error("indexed opcode misclassified");
  a_fields_split: assert property (
    DONE_OUT |-> {OP_MODE_OUT, OP_DST_OUT, OP_SRC_OUT} == OPCODE_OUT)
    else $error("opcode fields disagree");

  c_format_four_imm: cover property (fin_imm);
  c_directive:       cover property (fin_dir);
  c_long_disp:       cover property (take && state_r == ST_DISP &&
                                     disp_cnt_r == 2'h2);

endmodule : fmt_dec

//--- tb/fetch_model.sv
// Fetch unit model that hands instruction bytes to the decoder
`timescale 1ns/1ns
module fetch_model (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // Byte handshake
  input  wire logic       ready_in,
  input  wire logic       slow_in,
  output logic            valid_out,
  output logic [7:0]      byte_out
);
  logic [7:0] q[$];

  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask : push

  function automatic int pending();
    return q.size();
  endfunction : pending

  // ****************************************
  // Byte offer, held until taken
  // ****************************************
  // Idle lane inverts its byte on every idle cycle, so it alternates between the last byte and its inverse
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      valid_out <= 1'b0;
      byte_out  <= 8'h00;
    end else if (!(valid_out && !ready_in)) begin
      if (valid_out) begin
        q.delete(0);
      end
      // Slow mode leaves one idle cycle after every accepted byte
      if (q.size() != 0 && !(slow_in && valid_out)) begin
        valid_out <= 1'b1;
        byte_out  <= q[0];
      end else begin
        valid_out <= 1'b0;
        byte_out  <= ~byte_out;
      end
    end
  end
endmodule : fetch_model

//--- tb/fmt_dec_tb.sv
// Self-checking bench for the instruction format decoder
`timescale 1ns/1ns
module fmt_dec_tb;
  import fmt_dec_pkg::*;
  typedef logic [7:0] bytes_t[$];
  logic        clk_sys = 1'b0;
  logic        rst_n   = 1'b0;
  logic        slow    = 1'b0;
  logic        bvalid, bready, done, imm_v, directive;
  logic [7:0]  bdata, opcode;
  logic [1:0]  fmt, esc, mode, dlen;
  logic [2:0]  dst, src, dcode;
  logic [23:0] disp;
  logic [15:0] imm;
  int          n_errors     = 0;
  int          total_checks = 0;
  int          cycles       = 0;

  always #5 clk_sys = ~clk_sys;

  fetch_model fetch (.clk_in(clk_sys), .rst_n_in(rst_n), .ready_in(bready),
    .slow_in(slow), .valid_out(bvalid), .byte_out(bdata));

  fmt_dec dut (.CLK_SYS_IN(clk_sys), .RST_N_IN(rst_n),
    .BYTE_VALID_IN(bvalid), .BYTE_IN(bdata), .BYTE_READY_OUT(bready),
    .DONE_OUT(done), .FORMAT_OUT(fmt), .ADDR_ESC_OUT(esc),
    .OPCODE_OUT(opcode), .OP_MODE_OUT(mode), .OP_DST_OUT(dst),
    .OP_SRC_OUT(src), .DISP_OUT(disp), .DISP_LEN_OUT(dlen),
    .IMM_OUT(imm), .IMM_VALID_OUT(imm_v), .DIRECTIVE_OUT(directive),
    .DIRECTIVE_CODE_OUT(dcode));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic print_verdict;
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic feed(input bytes_t s);
    foreach (s[i]) begin
      fetch.push(s[i]);
    end
  endtask : feed

  // Bounded wait for a completion or directive pulse
  task automatic wait_pulse(input logic dir);
    int i;
    for (i = 0; i < 40; i++) begin
      @(negedge clk_sys);
      if ((dir ? directive : done) === 1'b1) break;
    end
    chk(24'(i < 40), 24'h1);
  endtask : wait_pulse

  task automatic expect_instr(input logic [1:0] f, input logic [1:0] e,
      input logic [7:0] op, input logic [23:0] d, input logic [1:0] dl,
      input logic [15:0] im, input logic iv);
    wait_pulse(1'b0);
    chk(fmt, f);
    chk(esc, e);
    chk(opcode, op);
    chk({mode, dst, src}, op);
    chk(disp, d);
    chk(dlen, dl);
    chk({imm_v, imm}, {iv, im});
  endtask : expect_instr

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_formats;
    feed({8'h01});
    expect_instr(FMT_1, AM_NONE, 8'h01, 24'h0, 2'h0, 16'h0, 1'b0);
    feed({8'hCB, 8'h01});
    expect_instr(FMT_3, AM_NONE, 8'h01, 24'h0, 2'h0, 16'h0, 1'b0);
    feed({8'hED, 8'h01});
    expect_instr(FMT_2, AM_NONE, 8'h01, 24'h0, 2'h0, 16'h0, 1'b0);
    feed({8'hDD, 8'h46});
    expect_instr(FMT_2, AM_FIRST, 8'h46, 24'h0, 2'h0, 16'h0, 1'b0);
    feed({8'hFD, 8'hCB, 8'h12, 8'h66});
    expect_instr(FMT_3, AM_SECOND, 8'h66, 24'h12, 2'h1, 16'h0, 1'b0);
  endtask : t_formats

  task automatic t_format4;
    feed({8'h01, 8'hED, 8'hCB, 8'h01, 8'hED, 8'hCB, 8'hBF, 8'h34, 8'h12});
    expect_instr(FMT_1, AM_NONE, 8'h01, 24'h0, 2'h0, 16'h0, 1'b0);
    expect_instr(FMT_4, AM_NONE, 8'h01, 24'h0, 2'h0, 16'h0, 1'b0);
    expect_instr(FMT_4, AM_NONE, 8'hBF, 24'h0, 2'h0, 16'h1234, 1'b1);
    @(negedge clk_sys);
    chk(done, 1'b0);
    slow <= 1'b1;
    feed({8'hED, 8'hCB, 8'hBF, 8'h78, 8'h56});
    expect_instr(FMT_4, AM_NONE, 8'hBF, 24'h0, 2'h0, 16'h5678, 1'b1);
    slow <= 1'b0;
  endtask : t_format4

  task automatic t_extend;
    bytes_t      s;
    logic [23:0] d;
    for (int k = 1; k <= 3; k++) begin
      feed({8'hDD, 8'hC0 | 8'(k)});
      wait_pulse(1'b1);
      chk(dcode, 24'(k));
      s = {8'hDD, 8'hCB};
      d = 24'h0;
      for (int j = 0; j < k; j++) begin
        s.push_back(8'h11 * 8'(j + 1));
        d = d | (24'(8'h11 * 8'(j + 1)) << (8 * j));
      end
      s.push_back(8'h5E);
      feed(s);
      expect_instr(FMT_3, AM_FIRST, 8'h5E, d, 2'(k), 16'h0, 1'b0);
    end
  endtask : t_extend

  task automatic t_directives;
    for (int k = 0; k < 8; k++) begin
      feed({(k[0] ? 8'hFD : 8'hDD), 8'hC0 | 8'(k)});
      wait_pulse(1'b1);
      chk(dcode, 24'(k));
    end
  endtask : t_directives

  task automatic t_reset;
    feed({8'hDD, 8'hCB});
    repeat (6) @(negedge clk_sys);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    @(negedge clk_sys);
    chk({bready, done}, 2'h0);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk(bready, 1'b1);
    feed({8'h46});
    expect_instr(FMT_1, AM_NONE, 8'h46, 24'h0, 2'h0, 16'h0, 1'b0);
  endtask : t_reset

  // ****************************************
  // Main sequence and hang guard
  // ****************************************
  // Whole run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      print_verdict();
    end
  end

  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_formats();
    t_format4();
    t_extend();
    t_directives();
    t_reset();
    print_verdict();
  end
endmodule : fmt_dec_tb
